// file: core/mpdp_data_port.sv
// Nibble data port of a 10/100 transceiver, facing the media access controller
`timescale 1ns/1ps

//Contract
// - The transmit clock toward the controller runs at 25 MHz at 100 Mb/s and 2.5 MHz at 10 Mb/s, divided from the reference.
// - The receive clock toward the controller runs at 25 MHz at 100 Mb/s and 2.5 MHz at 10 Mb/s.
// - Receive nibbles are driven as one four-bit value synchronous to the receive clock.
// - Receive data valid is high only while the receive nibble is valid, and the controller trusts data only then.
// - At 100 Mb/s receive error rises, synchronous to the receive clock, for an invalid symbol inside a packet.
// - Carrier sense is high whenever the receive medium is busy and low when it is idle.
// - In half duplex at either speed, collision is high while transmit and receive activity overlap.
// - At 10 Mb/s half duplex with heartbeat on, collision also pulses for about 1 us after each transmission.
// - In full duplex at either speed, collision stays low.
// - At 10 Mb/s full duplex no heartbeat pulse follows a transmission.
module mpdp_data_port
   import mpdp_pkg::*;
(
   // System
   input  wire logic         clk_sys,
   input  wire logic         rst,
   // Mode straps
   input  wire logic         speed100,
   input  wire logic         fullDuplex,
   input  wire logic         heartbeatEn,
   // Controller transmit side
   output logic              txClk,
   input  wire logic         txEn,
   input  wire logic [3:0]   txData,
   // Controller receive side
   output logic              rxClk,
   output logic              rxDv,
   output logic              rxEr,
   output logic [3:0]        rxData,
   output logic              crs,
   output logic              col,
   // Line transmit side
   output logic              lineTxValid,
   output logic [3:0]        lineTxData,
   // Line receive side
   input  wire logic         lineRxValid,
   output logic              lineRxReady,
   input  wire mpdp_nibble_t lineRxNibble,
   input  wire logic         lineCarrier
);

   logic [6:0]   divCnt_reg;
   logic         clkLvl_reg;
   logic         txEnS_reg;
   logic         lineTxValid_reg;
   logic [3:0]   lineTxData_reg;
   logic [7:0]   hbCnt_reg;
   logic         crs_reg;
   logic         col_reg;
   logic         rxDv_reg;
   logic         rxEr_reg;
   logic [3:0]   rxData_reg;
   mpdp_nibble_t bufMem_reg [2];
   logic         wrPtr_reg;
   logic         rdPtr_reg;
   logic [1:0]   count_reg;

   // Divider decode
   wire  [6:0]   halfCyc   = speed100 ? HALF_100_CYC : HALF_10_CYC;
   wire          halfEnd   = divCnt_reg >= (halfCyc - 7'h1);
   wire          riseTick  = halfEnd & ~clkLvl_reg;
   wire          fallTick  = halfEnd & clkLvl_reg;

   // Transmit and heartbeat decode
   wire          txEnd     = riseTick & txEnS_reg & ~txEn;
   wire          hbAllowed = ~speed100 & ~fullDuplex & heartbeatEn;
   wire          hbActive  = hbCnt_reg != 8'h00;

   // Buffer decode
   wire          bufEmpty  = count_reg == 2'h0;
   wire          push      = lineRxValid & lineRxReady;
   wire          pop       = fallTick & ~bufEmpty;
   mpdp_nibble_t bufHead;

   assign bufHead     = bufMem_reg[rdPtr_reg];
   assign lineRxReady = count_reg != BUF_DEPTH;
   assign txClk       = clkLvl_reg;
   assign rxClk       = clkLvl_reg;
   assign lineTxValid = lineTxValid_reg;
   assign lineTxData  = lineTxData_reg;
   assign rxDv        = rxDv_reg;
   assign rxEr        = rxEr_reg;
   assign rxData      = rxData_reg;
   assign crs         = crs_reg;
   assign col         = col_reg;

   // Link clock divider
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         divCnt_reg <= 7'h00;
         clkLvl_reg <= LINK_CLK_RST;
      end
      else if (halfEnd)
      begin
         divCnt_reg <= 7'h00;
         clkLvl_reg <= ~clkLvl_reg;
      end
      else
      begin
         divCnt_reg <= divCnt_reg + 7'h01;
      end
   end

   // Transmit sampling on the rising link clock
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         txEnS_reg       <= 1'h0;
         lineTxValid_reg <= 1'h0;
         lineTxData_reg  <= NIBBLE_RST;
      end
      else
      begin
         lineTxValid_reg <= riseTick & txEn;
         if (riseTick)
         begin
            txEnS_reg      <= txEn;
            lineTxData_reg <= txData;
         end
      end
   end

   // Heartbeat timer
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         hbCnt_reg <= 8'h00;
      else if (txEnd && hbAllowed)
         hbCnt_reg <= HB_CYC;
      else if (hbActive)
         hbCnt_reg <= hbCnt_reg - 8'h01;
   end

   // Carrier sense and collision
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         crs_reg <= 1'h0;
         col_reg <= 1'h0;
      end
      else
      begin
         crs_reg <= lineCarrier;
         col_reg <= ~fullDuplex & ((txEnS_reg & lineCarrier) | hbActive);
      end
   end

   // Two-entry receive buffer
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         wrPtr_reg <= 1'h0;
         rdPtr_reg <= 1'h0;
         count_reg <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            bufMem_reg[wrPtr_reg] <= lineRxNibble;
            wrPtr_reg             <= ~wrPtr_reg;
         end
         if (pop)
            rdPtr_reg <= ~rdPtr_reg;
         count_reg <= count_reg + {1'h0, push} - {1'h0, pop};
      end
   end

   // Receive outputs change on the falling link clock
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         rxDv_reg   <= 1'h0;
         rxEr_reg   <= 1'h0;
         rxData_reg <= NIBBLE_RST;
      end
      else if (fallTick)
      begin
         rxDv_reg   <= ~bufEmpty;
         rxEr_reg   <= ~bufEmpty & bufHead.err & speed100;
         rxData_reg <= bufEmpty ? NIBBLE_RST : bufHead.data;
      end
   end

   // Checks
   property p_txclk_100;
      @(posedge clk_sys) disable iff (rst || !speed100)
      $rose(txClk) |-> txClk[*4] ##1 !txClk;
   endproperty
   a_txclk_100: assert property (p_txclk_100) else $error("Fast transmit clock half period wrong");

   property p_rxclk_10;
      @(posedge clk_sys) disable iff (rst || speed100)
      $rose(rxClk) |-> rxClk ##39 rxClk ##1 !rxClk;
   endproperty
   a_rxclk_10: assert property (p_rxclk_10) else $error("Slow receive clock half period wrong");

   sequence s_headPop;
      fallTick && !bufEmpty;
   endsequence

   property p_rxdata;
      @(posedge clk_sys) disable iff (rst)
      s_headPop |=> rxDv && rxData == $past(bufHead.data);
   endproperty
   a_rxdata: assert property (p_rxdata) else $error("Receive nibble not taken from buffer");

   property p_rxdv_empty;
      @(posedge clk_sys) disable iff (rst)
      fallTick && bufEmpty |=> !rxDv;
   endproperty
   a_rxdv_empty: assert property (p_rxdv_empty) else $error("Data valid without a nibble");

   property p_rxer;
      @(posedge clk_sys) disable iff (rst)
      $rose(rxEr) |-> rxDv && $past(speed100);
   endproperty
   a_rxer: assert property (p_rxer) else $error("Receive error outside a fast packet");

   property p_crs;
      @(posedge clk_sys) disable iff (rst)
      lineCarrier |=> crs;
   endproperty
   a_crs: assert property (p_crs) else $error("Carrier sense missed busy medium");

   property p_crs_idle;
      @(posedge clk_sys) disable iff (rst)
      !lineCarrier |=> !crs;
   endproperty
   a_crs_idle: assert property (p_crs_idle) else $error("Carrier sense high on idle medium");

   property p_col;
      @(posedge clk_sys) disable iff (rst)
      !fullDuplex && txEnS_reg && lineCarrier |=> col;
   endproperty
   a_col: assert property (p_col) else $error("Collision not flagged");

   sequence s_txEndHb;
      txEnd && hbAllowed;
   endsequence

   property p_hb;
      @(posedge clk_sys) disable iff (rst || fullDuplex)
      s_txEndHb |-> ##2 col[*8] ##192 col;
   endproperty
   a_hb: assert property (p_hb) else $error("Heartbeat pulse too short");

   property p_col_fd;
      @(posedge clk_sys) disable iff (rst)
      fullDuplex ##1 fullDuplex |-> !col;
   endproperty
   a_col_fd: assert property (p_col_fd) else $error("Collision high in full duplex");

   property p_nohb_fd;
      @(posedge clk_sys) disable iff (rst)
      txEnd && fullDuplex && !hbActive |=> !hbActive;
   endproperty
   a_nohb_fd: assert property (p_nohb_fd) else $error("Heartbeat in full duplex");

   property p_txsample;
      @(posedge clk_sys) disable iff (rst)
      riseTick |=> txEnS_reg == $past(txEn) && lineTxData == $past(txData);
   endproperty
   a_txsample: assert property (p_txsample) else $error("Transmit inputs not sampled on rising edge");

endmodule // mpdp_data_port

// file: core/mpdp_pkg.sv
// Shared constants and carrier types for the nibble data port
package mpdp_pkg;

   // System clock and divided link clock rates
   localparam int CLK_SYS_KHZ   = 200000;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int LINK_100_KHZ  = 25000;
   localparam int LINK_10_KHZ   = 2500;

   // Half periods of the link clocks in system cycles
   localparam logic [6:0] HALF_100_CYC = 7'(CLK_SYS_KHZ / (2 * LINK_100_KHZ));
   localparam logic [6:0] HALF_10_CYC  = 7'(CLK_SYS_KHZ / (2 * LINK_10_KHZ));

   // Heartbeat pulse length
   localparam int         HB_TIME_NS = 1000;
   localparam logic [7:0] HB_CYC     = 8'(HB_TIME_NS * 1000 / CLK_PERIOD_PS);

   // Receive buffer depth and reset values
   localparam logic [1:0] BUF_DEPTH  = 2'h2;
   localparam logic       LINK_CLK_RST = 1'h0;
   localparam logic [3:0] NIBBLE_RST   = 4'h0;

   // Nibble with its error mark
   typedef struct packed {
      logic [3:0] data;
      logic       err;
   } mpdp_nibble_t;

endpackage

// file: testbench/mpdp_mac_model.sv
// Controller model sending queued nibbles on the transmit clock
`timescale 1ns/1ps
module mpdp_mac_model
(
   // Clocks
   input  wire logic clk_sys,
   input  wire logic txClk,
   // Transmit side
   output logic       txEn,
   output logic [3:0] txData
);
   logic [3:0] q[$];
   logic       clkPrev = 1'h0;
   initial txEn = 1'h0;
   initial txData = 4'h0;
   // One nibble per transmit clock period, held across the next rise
   always @(negedge clk_sys)
   begin
      if (txClk && !clkPrev)
      begin
         txEn <= (q.size() != 0);
         if (q.size() != 0)
            txData <= q.pop_front();
         else
            txData <= ~txData;
      end
      clkPrev <= txClk;
   end
endmodule // mpdp_mac_model

// file: testbench/tb_top.sv
// Self-checking bench for the nibble data port
`timescale 1ns/1ps
module tb_top;
   import mpdp_pkg::*;
   logic         clk_sys = 1'h0, rst = 1'h1, speed100 = 1'h1, fullDuplex = 1'h0, heartbeatEn = 1'h0;
   logic         txClk, txEn, rxClk, rxDv, rxEr, crs, col, lineTxValid, lineRxReady;
   logic         lineRxValid = 1'h0, lineCarrier = 1'h0;
   logic [3:0]   txData, rxData, lineTxData;
   mpdp_nibble_t lineRxNibble = '0;
   logic [3:0]   txQ[$];
   mpdp_nibble_t rxQ[$];
   int           errors = 0, comparisons = 0, seed = 32'hB648, cyc = 0, colCnt = 0;

   mpdp_data_port DUT (
      .clk_sys      (clk_sys),
      .rst          (rst),
      .speed100     (speed100),
      .fullDuplex   (fullDuplex),
      .heartbeatEn  (heartbeatEn),
      .txClk        (txClk),
      .txEn         (txEn),
      .txData       (txData),
      .rxClk        (rxClk),
      .rxDv         (rxDv),
      .rxEr         (rxEr),
      .rxData       (rxData),
      .crs          (crs),
      .col          (col),
      .lineTxValid  (lineTxValid),
      .lineTxData   (lineTxData),
      .lineRxValid  (lineRxValid),
      .lineRxReady  (lineRxReady),
      .lineRxNibble (lineRxNibble),
      .lineCarrier  (lineCarrier)
   );
   mpdp_mac_model mac (.clk_sys(clk_sys), .txClk(txClk), .txEn(txEn), .txData(txData));

   initial forever #2.5 clk_sys = ~clk_sys;

   function automatic logic [7:0] rxExp(mpdp_nibble_t n);
      return {3'h0, n.err & speed100, n.data};
   endfunction

   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Outputs looked at mid-cycle, where they are settled
   always @(negedge clk_sys)
   begin
      cyc++;
      if (col === 1'h1)
         colCnt++;
      if (!rst && lineTxValid === 1'h1)
         check("lineTx", {4'h0, lineTxData}, {4'h0, txQ.pop_front()});
      if (cyc == 20000)
      begin
         errors++;
         print_verdict();
      end
   end

   always @(posedge rxClk)
      if (rxDv === 1'h1)
         check("rx", {3'h0, rxEr, rxData}, rxExp(rxQ.pop_front()));

   task automatic clk_period();
      int t;
      @(posedge txClk);
      t = cyc;
      @(posedge txClk);
      check("period", 8'(cyc - t), speed100 ? 8'h08 : 8'h50);
      @(negedge clk_sys);
      check("rxClk", {7'h0, rxClk}, 8'h01);
      @(posedge rxClk);
      t = cyc;
      @(posedge rxClk);
      check("rxPeriod", 8'(cyc - t), speed100 ? 8'h08 : 8'h50);
      @(negedge clk_sys);
   endtask

   task automatic col_run(int n, logic car, int exp);
      logic [3:0] d;
      @(negedge clk_sys);
      lineCarrier = car;
      colCnt = 0;
      repeat (n)
      begin
         d = 4'($random(seed));
         txQ.push_back(d);
         mac.q.push_back(d);
      end
      while (txQ.size() != 0)
         @(negedge clk_sys);
      repeat (300)
         @(negedge clk_sys);
      check("col", 8'(colCnt), 8'(exp));
      check("crs", {7'h0, crs}, {7'h0, car});
      lineCarrier = 1'h0;
   endtask

   task automatic rx_push(int n);
      mpdp_nibble_t x;
      repeat (n)
      begin
         x = 5'($random(seed));
         @(negedge clk_sys);
         lineRxNibble = x;
         lineRxValid = 1'h1;
         while (lineRxReady !== 1'h1)
            @(negedge clk_sys);
         rxQ.push_back(x);
         @(posedge clk_sys);
      end
      @(negedge clk_sys);
      lineRxValid = 1'h0;
      lineRxNibble = ~x;
      while (rxQ.size() != 0)
         @(negedge clk_sys);
   endtask

   initial
   begin
      repeat (6)
         @(negedge clk_sys);
      rst = 1'h0;
      clk_period();
      col_run(5, 1'h1, 40);
      col_run(2, 1'h0, 0);
      fullDuplex = 1'h1;
      col_run(5, 1'h1, 0);
      rx_push(8);
      speed100 = 1'h0;
      clk_period();
      rx_push(4);
      heartbeatEn = 1'h1;
      col_run(3, 1'h0, 0);
      fullDuplex = 1'h0;
      col_run(3, 1'h0, int'(HB_CYC));
      heartbeatEn = 1'h0;
      col_run(2, 1'h0, 0);
      // Mid-run reset: outputs idle, buffer open, clocks restart
      @(negedge clk_sys);
      rst = 1'h1;
      repeat (2)
         @(negedge clk_sys);
      check("reset", {txClk, rxClk, rxDv, rxEr, crs, col, lineTxValid, lineRxReady}, 8'h01);
      check("resetData", {4'h0, rxData}, 8'h00);
      rst = 1'h0;
      clk_period();
      print_verdict();
   end
endmodule // tb_top
